// ---- dsm_ctrl.sv ----
// operating-mode controller for a dual-channel protected high-side switch
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - no sequencing while supply is absent; stays off until powered
// - both channel enables and diagnostic enable low enters standby-delay
// - after standby delay with all enables still low, enter standby
// - standby keeps sense output and fault reporting unavailable
// - diag state: diag enable high, both channel enables low, switches off
// - active whenever a channel is enabled; diag enable free while active
// - thermal shutdown or current limit puts channel in fault, switch off
// - fault exits only when faults clear, latch low, retry expired
// - after fault, switch follows its own channel enable
// - channels are enabled and fault-handled fully independently
// - ground loss disables both switches; off switches stay off
// - ground restored resumes following the enable inputs
// - reverse current is not detected; no flag, no mode change
// - open-load and short-to-supply detect only with diag high, channel off
module dsm_ctrl #(
  parameter int STBY_CYC   = dsm_pkg::DSM_STBY_CYC,
  parameter int RETRY_CYC  = dsm_pkg::DSM_RETRY_CYC,
  parameter int SETTLE_CYC = dsm_pkg::DSM_SETTLE_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        supply_ok,
  input  wire logic        ground_ok,
  input  wire logic [1:0]  thermal_fault,
  input  wire logic [1:0]  current_fault,
  input  wire logic [1:0]  out_above_ol,
  input  wire logic        reverse_current,
  output logic      [1:0]  switch_on,
  output logic             sense_enable,
  output logic             sense_valid,
  output logic      [1:0]  detect_fault,
  output logic             irq
);
  import dsm_pkg::*;

  // ****************************************
  // register bus
  // ****************************************
  logic [31:0]         ctrl_q, ctrl_d;
  logic [DSM_IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
  logic [31:0]         settle_q, settle_d;
  logic                wr, rd_hit;
  logic [1:0]          en;
  logic                diag_en, latch_in;
  dsm_mode_t           mode_q, mode_d;
  dsm_ch_t             ch_q [2];
  dsm_ch_t             ch_d [2];
  logic [DSM_CNT_W-1:0] stby_cnt_q, stby_cnt_d;
  logic [DSM_CNT_W-1:0] retry_q [2];
  logic [DSM_CNT_W-1:0] retry_d [2];
  logic [DSM_CNT_W-1:0] settle_cnt_q, settle_cnt_d;
  logic                gnd_seen_q;
  logic [1:0]          en_prev_q;

  assign wr      = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign en      = {ctrl_q[DSM_CTRL_CH2_EN], ctrl_q[DSM_CTRL_CH1_EN]};
  assign diag_en = ctrl_q[DSM_CTRL_DIAG];
  assign latch_in = ctrl_q[DSM_CTRL_LATCH];

  always_comb begin
    rd_hit = 1'b1;
    prdata = 32'h0000_0000;
    if (paddr == DSM_CTRL_ADDR) begin
      prdata = ctrl_q;
    end else if (paddr == DSM_STATE_ADDR) begin
      prdata[DSM_ST_MODE_LSB +: 3] = mode_q;
      prdata[DSM_ST_CH1_BIT]      = (ch_q[0] == DSM_CH_FAULT);
      prdata[DSM_ST_CH2_BIT]      = (ch_q[1] == DSM_CH_FAULT);
      prdata[DSM_ST_SW1_BIT]      = switch_on[0];
      prdata[DSM_ST_SW2_BIT]      = switch_on[1];
      prdata[DSM_ST_SENSE_BIT]    = sense_valid;
      prdata[DSM_ST_DET_LSB +: 2] = detect_fault;
    end else if (paddr == DSM_IRQ_ADDR) begin
      prdata[DSM_IRQ_W-1:0] = stat_q;
    end else if (paddr == DSM_MASK_ADDR) begin
      prdata[DSM_IRQ_W-1:0] = mask_q;
    end else if (paddr == DSM_SETTLE_ADDR) begin
      prdata = settle_q;
    end else begin
      rd_hit = 1'b0;
    end
    pslverr = psel & penable & ~rd_hit;
  end

  // reverse_current is deliberately never read: no flag, no mode change
  always_comb begin
    ctrl_d   = ctrl_q;
    mask_d   = mask_q;
    settle_d = settle_q;
    stat_d   = stat_q;
    if (wr && paddr == DSM_CTRL_ADDR) ctrl_d = pwdata;
    if (wr && paddr == DSM_MASK_ADDR) mask_d = pwdata[DSM_IRQ_W-1:0];
    if (wr && paddr == DSM_SETTLE_ADDR) settle_d = pwdata;
    if (wr && paddr == DSM_IRQ_ADDR) stat_d = stat_q & ~pwdata[DSM_IRQ_W-1:0];
    // set wins over a same-cycle clear
    stat_d = stat_d | ev;
  end

  assign irq = |(stat_q & mask_q);

  // ****************************************
  // device mode
  // ****************************************
  always_comb begin
    mode_d     = mode_q;
    stby_cnt_d = stby_cnt_q;
    if (!supply_ok) begin
      mode_d = DSM_OFF;
    end else if (|en) begin
      mode_d = DSM_ACTIVE;
    end else if (diag_en) begin
      mode_d = DSM_DIAG;
    end else begin
      case (mode_q)
        DSM_STBY: mode_d = DSM_STBY;
        DSM_STBY_DLY: begin
          if (stby_cnt_q >= DSM_CNT_W'(STBY_CYC - 1)) begin
            mode_d = DSM_STBY;
          end else begin
            stby_cnt_d = stby_cnt_q + 1'b1;
          end
        end
        default: begin
          mode_d     = DSM_STBY_DLY;
          stby_cnt_d = '0;
        end
      endcase
    end
  end

  // ****************************************
  // per-channel fault handling
  // ****************************************
  logic [1:0] sw_d;
  logic [1:0] fault_now;
  assign fault_now = thermal_fault | current_fault;

  for (genvar i = 0; i < 2; i++) begin : g_ch
    // each channel reads its own enable and fault inputs; supply_ok and the latch bit are shared
    always_comb begin
      ch_d[i]    = ch_q[i];
      retry_d[i] = retry_q[i];
      case (ch_q[i])
        DSM_CH_RUN: begin
          if (supply_ok && en[i] && fault_now[i]) begin
            ch_d[i]    = DSM_CH_FAULT;
            retry_d[i] = '0;
          end
        end
        default: begin
          if (retry_q[i] < DSM_CNT_W'(RETRY_CYC - 1)) begin
            retry_d[i] = retry_q[i] + 1'b1;
          end else if (!fault_now[i] && !latch_in) begin
            ch_d[i] = DSM_CH_RUN;
          end
        end
      endcase
    end

    // switch follows own enable after fault; ground loss forces off
    assign sw_d[i] = supply_ok && ground_ok && en[i] &&
                     (ch_d[i] == DSM_CH_RUN);
    // fault entry raises the channel's sticky status bit
    assign ev[i] = (ch_q[i] == DSM_CH_RUN) && (ch_d[i] == DSM_CH_FAULT);

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ch_q[i]    <= DSM_CH_RUN;
        retry_q[i] <= '0;
      end else begin
        ch_q[i]    <= ch_d[i];
        retry_q[i] <= retry_d[i];
      end
    end
  end

  assign ev[DSM_IRQ_STBY] = (mode_q != DSM_STBY) && (mode_d == DSM_STBY);
  assign ev[DSM_IRQ_GND]  = gnd_seen_q && !ground_ok;

  // ****************************************
  // sense gating
  // ****************************************
  // host-side settle wait is mirrored here as a ready hint
  always_comb begin
    settle_cnt_d = settle_cnt_q;
    if (|(en & ~en_prev_q)) begin
      settle_cnt_d = '0;
    end else if (settle_cnt_q < DSM_CNT_W'(SETTLE_CYC)) begin
      settle_cnt_d = settle_cnt_q + 1'b1;
    end
  end

  logic        sense_enable_d, sense_valid_d;
  logic [1:0]  detect_d;
  always_comb begin
    // sense and faults unavailable in standby and off
    sense_enable_d = diag_en && ground_ok &&
                     (mode_q == DSM_DIAG || mode_q == DSM_ACTIVE);
    sense_valid_d  = sense_enable_d &&
                     (settle_cnt_q >= DSM_CNT_W'(SETTLE_CYC));
    detect_d = {2{sense_enable_d}} &
               ((out_above_ol & ~en & ~switch_on) |
                {ch_q[1] == DSM_CH_FAULT, ch_q[0] == DSM_CH_FAULT});
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q       <= DSM_CTRL_RST;
      mask_q       <= '0;
      stat_q       <= '0;
      settle_q     <= '0;
      mode_q       <= DSM_OFF;
      stby_cnt_q   <= '0;
      settle_cnt_q <= '0;
      gnd_seen_q   <= 1'b0;
      en_prev_q    <= '0;
      switch_on    <= '0;
      sense_enable <= 1'b0;
      sense_valid  <= 1'b0;
      detect_fault <= '0;
    end else begin
      ctrl_q       <= ctrl_d;
      mask_q       <= mask_d;
      stat_q       <= stat_d;
      settle_q     <= settle_d;
      mode_q       <= mode_d;
      stby_cnt_q   <= stby_cnt_d;
      settle_cnt_q <= settle_cnt_d;
      gnd_seen_q   <= ground_ok;
      en_prev_q    <= en;
      switch_on    <= sw_d;
      sense_enable <= sense_enable_d;
      sense_valid  <= sense_valid_d;
      detect_fault <= detect_d;
    end
  end

endmodule

`default_nettype wire

// ---- dsm_pkg.sv ----
// package with states, register map and timing for the dual switch mode controller
package dsm_pkg;

  // ****************************************
  // states
  // ****************************************
  typedef enum logic [2:0] {
    DSM_OFF,
    DSM_STBY_DLY,
    DSM_STBY,
    DSM_DIAG,
    DSM_ACTIVE
  } dsm_mode_t;

  typedef enum logic [0:0] {
    DSM_CH_RUN,
    DSM_CH_FAULT
  } dsm_ch_t;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [11:0] DSM_CTRL_ADDR   = 12'h000;
  localparam logic [11:0] DSM_STATE_ADDR  = 12'h004;
  localparam logic [11:0] DSM_IRQ_ADDR    = 12'h008;
  localparam logic [11:0] DSM_MASK_ADDR   = 12'h00c;
  localparam logic [11:0] DSM_SETTLE_ADDR = 12'h010;

  // ctrl bits
  localparam int DSM_CTRL_CH1_EN = 0;
  localparam int DSM_CTRL_CH2_EN = 1;
  localparam int DSM_CTRL_DIAG  = 2;
  localparam int DSM_CTRL_LATCH = 3;
  localparam logic [31:0] DSM_CTRL_RST = 32'h0000_0000;

  // irq bits: fault ch1, fault ch2, standby entered, ground lost
  localparam int DSM_IRQ_F1   = 0;
  localparam int DSM_IRQ_F2   = 1;
  localparam int DSM_IRQ_STBY = 2;
  localparam int DSM_IRQ_GND  = 3;
  localparam int DSM_IRQ_W    = 4;

  // state register fields
  localparam int DSM_ST_MODE_LSB = 0;
  localparam int DSM_ST_CH1_BIT  = 4;
  localparam int DSM_ST_CH2_BIT  = 5;
  localparam int DSM_ST_SW1_BIT  = 6;
  localparam int DSM_ST_SW2_BIT  = 7;
  localparam int DSM_ST_SENSE_BIT = 8;
  localparam int DSM_ST_DET_LSB  = 9;

  // ****************************************
  // timing
  // ****************************************
  localparam int DSM_CLK_MHZ        = 125;
  localparam int DSM_STBY_US        = 1000;
  localparam int DSM_RETRY_US       = 2000;
  localparam int DSM_SETTLE_US      = 60;
  localparam int DSM_STBY_CYC       = DSM_STBY_US * DSM_CLK_MHZ;
  localparam int DSM_RETRY_CYC      = DSM_RETRY_US * DSM_CLK_MHZ;
  localparam int DSM_SETTLE_CYC     = DSM_SETTLE_US * DSM_CLK_MHZ;
  localparam int DSM_CNT_W          = 24;

endpackage

// ---- dsm_ctrl_props.sv ----
// port assertions for the mode controller
`timescale 1ns/1ns
`default_nettype none
module dsm_ctrl_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        supply_ok,
  input wire logic        ground_ok,
  input wire logic [1:0]  thermal_fault,
  input wire logic [1:0]  current_fault,
  input wire logic        reverse_current,
  input wire logic [1:0]  switch_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic [1:0] flt = thermal_fault | current_fault;
  wire logic       wr = psel && penable && pwrite;
  // a ctrl write lands two edges later, so look one write back
  wire logic calm = supply_ok && ground_ok && !wr;
  sequence s_trip; switch_on[0] && flt[0]; endsequence
  sequence s_hold; !switch_on[0] [*8]; endsequence
  chk_power_off: assert property (!supply_ok |=> switch_on == 2'h0)
    else $error("switch on without supply");
  chk_ground_off: assert property (!ground_ok |=> switch_on == 2'h0)
    else $error("switch on without ground");
  chk_fault_trip: assert property (switch_on[1] && flt[1]
    |=> !switch_on[1])
    else $error("switch two kept on in fault");
  chk_retry_hold: assert property (s_trip |=> s_hold)
    else $error("switch one back before retry");
  chk_chan_indep: assert property (switch_on[1] && flt[0]
    && !flt[1] && calm && !$past(wr) |=> switch_on[1])
    else $error("fault on one hit the other");
  chk_rev_ignore: assert property (switch_on == 2'h3
    && reverse_current && flt == 2'h0 && calm && !$past(wr)
    |=> switch_on == 2'h3)
    else $error("reverse current changed switches");
  chk_apb_ready: assert property (psel |-> pready)
    else $error("pready low");
  chk_apb_err: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
    else $error("no error on unmapped access");
  chk_apb_ok: assert property (psel && penable && paddr[1:0] == 2'h0
    && paddr <= 12'h010 |-> !pslverr)
    else $error("error on mapped access");
endmodule
bind dsm_ctrl dsm_ctrl_props u_props (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .supply_ok(supply_ok), .ground_ok(ground_ok),
  .thermal_fault(thermal_fault), .current_fault(current_fault),
  .reverse_current(reverse_current), .switch_on(switch_on));
`default_nettype wire

// ---- dsm_host.sv ----
// host model that samples the sense output once settled
`timescale 1ns/1ns
`default_nettype none
module dsm_host #(
  parameter int SETTLE_CYC = 10
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sense_enable,
  input  wire logic sense_valid,
  output logic      sample_ok
);
  int cnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 0;
      sample_ok <= 1'b0;
    end else if (!sense_enable) begin
      cnt_q <= 0;
    end else if (cnt_q < SETTLE_CYC) begin
      cnt_q <= cnt_q + 1;
    end else begin
      sample_ok <= sense_valid;
    end
  end
endmodule
`default_nettype wire

// ---- dsm_ctrl_test.sv ----
// self-checking bench for the mode controller
`timescale 1ns/1ns
`default_nettype none
module dsm_ctrl_test;
  import dsm_pkg::*;
  localparam int STBY = 20;
  localparam int SETTLE = 10;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd_q, c;
  logic        pready, pslverr, err_q, irq, sense_enable, sense_valid;
  logic        sample_ok, supply_ok = 0, ground_ok = 1, reverse_current = 0;
  logic [1:0]  thermal_fault = '0, current_fault = '0, out_above_ol = '0;
  logic [1:0]  switch_on, detect_fault;
  int          error_cnt = 0, comparisons = 0;
  dsm_ctrl #(.STBY_CYC(STBY), .RETRY_CYC(30), .SETTLE_CYC(SETTLE)) u_dut (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .supply_ok, .ground_ok, .thermal_fault, .current_fault,
    .out_above_ol, .reverse_current, .switch_on, .sense_enable,
    .sense_valid, .detect_fault, .irq);
  dsm_host #(.SETTLE_CYC(SETTLE)) u_host (.clk, .rst, .sense_enable,
    .sense_valid, .sample_ok);
  initial forever #4 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // idle edge at the end keeps psel from being driven twice in one step
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk("pready", pready, 1'b1);
    if (pready !== 1'b1) final_report();
    err_q = pslverr;
    rd_q = prdata;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  task automatic wait_sw(input logic [1:0] e, input int n);
    int k = 0;
    while (switch_on !== e && k < n) begin
      @(posedge clk);
      k++;
    end
    chk("switch wait", switch_on, e);
    if (switch_on !== e) final_report();
  endtask
  task automatic mode(input logic [2:0] e);
    apb(0, DSM_STATE_ADDR, '0);
    chk("mode", rd_q[2:0], e);
  endtask
  task automatic flt(input logic [3:0] m, input logic [31:0] w, input int n,
                     input logic [1:0] e);
    {current_fault, thermal_fault} <= m;
    cyc(3);
    {current_fault, thermal_fault} <= 4'h0;
    apb(1, DSM_CTRL_ADDR, w);
    cyc(n);
    chk("switch after fault", switch_on, e);
  endtask
  function automatic logic [2:0] exp_mode(input logic [2:0] v);
    if (v[1:0] != 2'h0) return DSM_ACTIVE;
    return v[2] ? DSM_DIAG : DSM_STBY_DLY;
  endfunction
  initial begin
    void'($urandom(32'h54641497));
    cyc(4);
    rst <= 0;
    cyc(1);
    apb(0, DSM_CTRL_ADDR, '0);
    chk("ctrl reset", rd_q, DSM_CTRL_RST);
    apb(1, DSM_CTRL_ADDR, 32'h3);
    cyc(3);
    mode(DSM_OFF);
    chk("sw unpowered", switch_on, 2'h0);
    $display("power test done");
    apb(1, DSM_CTRL_ADDR, 32'h0);
    supply_ok <= 1; out_above_ol <= 2'h3;
    cyc(5);
    mode(DSM_STBY_DLY);
    apb(1, DSM_CTRL_ADDR, 32'h4);
    cyc(2);
    mode(DSM_DIAG);
    chk("sw diag", switch_on, 2'h0);
    apb(1, DSM_CTRL_ADDR, 32'h0);
    cyc(14);
    mode(DSM_STBY_DLY);
    cyc(8);
    mode(DSM_STBY);
    chk("sense stby", {detect_fault, sense_valid, sense_enable}, 4'h0);
    apb(0, DSM_IRQ_ADDR, '0);
    chk("irq stby", rd_q[DSM_IRQ_STBY], 1'b1);
    apb(1, DSM_IRQ_ADDR, 32'hf);
    apb(1, DSM_CTRL_ADDR, 32'h4);
    cyc(SETTLE + 5);
    chk("settled sample", sample_ok, 1'b1);
    chk("sense valid", sense_valid, 1'b1);
    $display("standby test done");
    repeat (16) begin
      c = $urandom & 32'h7;
      if (c == 0) c = 32'h4;
      reverse_current <= 1'($urandom);
      out_above_ol <= 2'($urandom);
      apb(1, DSM_CTRL_ADDR, c);
      cyc(2);
      chk("sw", switch_on, c[1:0]);
      chk("det", detect_fault, c[2] ? out_above_ol & ~c[1:0] : 2'h0);
      mode(exp_mode(c[2:0]));
    end
    $display("random test done");
    apb(1, DSM_CTRL_ADDR, 32'hb);
    cyc(3);
    flt(4'h1, 32'hb, 40, 2'h2);
    apb(1, DSM_CTRL_ADDR, 32'h3);
    wait_sw(2'h3, 10);
    flt(4'h8, 32'h3, 12, 2'h1);
    wait_sw(2'h3, 40);
    flt(4'h2, 32'h1, 45, 2'h1);
    apb(0, DSM_IRQ_ADDR, '0);
    chk("irq faults", rd_q[1:0], 2'h3);
    apb(1, DSM_MASK_ADDR, 32'h1);
    chk("irq on", irq, 1'b1);
    apb(1, DSM_IRQ_ADDR, 32'h1);
    chk("irq masked", irq, 1'b0);
    $display("fault test done");
    apb(1, DSM_CTRL_ADDR, 32'h3);
    wait_sw(2'h3, 40);
    ground_ok <= 0;
    cyc(3);
    chk("sw no ground", switch_on, 2'h0);
    apb(0, DSM_IRQ_ADDR, '0);
    chk("irq ground", rd_q[DSM_IRQ_GND], 1'b1);
    ground_ok <= 1;
    wait_sw(2'h3, 5);
    apb(1, 12'h020, 32'h5);
    chk("wr unmapped", err_q, 1'b1);
    apb(0, 12'h020, '0);
    chk("rd unmapped", {err_q, rd_q}, {1'b1, 32'h0});
    $display("ground and bus test done");
    final_report();
  end
endmodule
`default_nettype wire
